// File: rtl/alarm_pkg.sv
// Contract
// - Flag all-zero 8-bit write pointer
// - Freeze zero write pointer until next sync
// - FIFO nearness/collision field in bits 13:11
// - Bit 10 flags conversion clock lost
// - Bit 9 flags input data clock lost
// - Bit 8 follows clock-lost or collision alarms
// - Output-gone forces midscale 0x8000 on channels
// - Bit 7 flags pattern checker mismatch
// - Bit 5 flags clock multiplier lock loss
// - Dual parity: bit 4 is A word
// - Single parity: bit 4 is rising-edge data
// - Bit 3: B word or falling-edge data
// - Dual parity only: bits 2, 1 are C, D
// - Status at index 0x05, bits cleared by writing ones
// - Mask register, one masks, all masked at reset
package alarm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] STATUS_IDX = 8'h05;
  localparam logic [7:0] MASK_IDX = 8'h07;
  localparam logic [7:0] CTRL_IDX = 8'h10;
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [11:0] MASK_ADDR = {2'b00, MASK_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};

  // Status bit positions
  localparam int BIT_ZERO = 15;
  localparam int BIT_COLL = 13;
  localparam int BIT_ONE = 12;
  localparam int BIT_TWO = 11;
  localparam int BIT_DACCLK = 10;
  localparam int BIT_DATACLK = 9;
  localparam int BIT_OUTGONE = 8;
  localparam int BIT_IOTEST = 7;
  localparam int BIT_PLL = 5;
  localparam int BIT_PA = 4;
  localparam int BIT_PB = 3;
  localparam int BIT_PC = 2;
  localparam int BIT_PD = 1;
  localparam logic [15:0] RESERVED_BITS = 16'h4041;

  // Control bit positions
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_PATTERN = 1;
  localparam int CTRL_SYNC = 2;

  // Reset values
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hffff;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] PTR_RESET = 8'h01;
  localparam logic [15:0] MIDSCALE = 16'h8000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [3:0][15:0] ch;
  } samples_t;

  // Alarm sources from other clock domains
  typedef struct packed {
    logic dacclk_stopped;
    logic input_data_clock_stopped;
    logic pll_unlocked;
    logic par_rise;
    logic par_fall;
    logic [3:0] par_word;
  } async_alarms_t;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DONE = 4'h8
  } bus_state_t;

endpackage : alarm_pkg

// File: rtl/alarm_cells.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; first stage feeds only the second
module level_sync
  import alarm_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;
endmodule : level_sync

// Sticky flags; a set in the clear cycle wins
module sticky_bank
  import alarm_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] flags;
  } sticky_state_t;

  sticky_state_t st_r;
  sticky_state_t st_nxt;

  always_comb begin
    st_nxt.flags = (st_r.flags & ~clr) | set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.flags;
endmodule : sticky_bank

`default_nettype wire

// File: rtl/alarm_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module alarm_status_regs
  import alarm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Alarm sources, asynchronous
  input wire async_alarms_t async_alarms,
  // Alarm sources, mclk domain
  input wire logic pattern_mismatch,
  input wire logic fifo_wr_advance,
  input wire logic [7:0] fifo_rd_ptr,
  input wire logic sync_event,
  input wire logic [7:0] sync_ptr_value,
  // FIFO pointer and mode outputs
  output logic [7:0] fifo_wr_ptr,
  output logic pattern_mode,
  // Converter data path
  input wire samples_t samples_in,
  output samples_t samples_out,
  // Alarm pin, set by status bits the mask register leaves unmasked
  output logic alarm_out
);
  typedef struct packed {
    bus_state_t bus;
    logic [11:0] addr;
    logic size_ok;
    logic [31:0] rdata;
    logic [15:0] mask;
    logic [2:0] ctrl;
    logic sync_pend;
    logic [7:0] wr_ptr;
    samples_t samples;
    logic alarm;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;

  async_alarms_t alarms_s;
  logic [15:0] status;
  logic [15:0] status_set;
  logic [15:0] status_clr;
  logic do_write;
  logic accept;
  logic collision;
  logic one_away;
  logic two_away;
  logic ptr_zero;
  logic dual;

  level_sync #(.W($bits(async_alarms_t))) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(async_alarms),
    .q(alarms_s)
  );

  sticky_bank #(.W(16)) u_status (
    .mclk(mclk),
    .rst(rst),
    .set(status_set),
    .clr(status_clr),
    .q(status)
  );

  // Pointers are one-hot rings, so distance is a rotation match
  always_comb begin
    ptr_zero = (st_r.wr_ptr == 8'h00);
    collision = (st_r.wr_ptr == fifo_rd_ptr);
    one_away = ({st_r.wr_ptr[6:0], st_r.wr_ptr[7]} == fifo_rd_ptr);
    two_away = ({st_r.wr_ptr[5:0], st_r.wr_ptr[7:6]} == fifo_rd_ptr);
    dual = st_r.ctrl[CTRL_DUAL];
  end

  always_comb begin
    status_set = 16'h0000;
    status_set[BIT_ZERO] = ptr_zero;
    status_set[BIT_COLL] = collision && !ptr_zero;
    status_set[BIT_ONE] = one_away && !ptr_zero;
    status_set[BIT_TWO] = two_away && !ptr_zero;
    status_set[BIT_DACCLK] = alarms_s.dacclk_stopped;
    status_set[BIT_DATACLK] = alarms_s.input_data_clock_stopped;
    // Re-asserts while a source bit stays set, so it cannot be cleared alone
    status_set[BIT_OUTGONE] = alarms_s.dacclk_stopped | alarms_s.input_data_clock_stopped
                            | status_set[BIT_COLL] | status[BIT_DACCLK]
                            | status[BIT_DATACLK] | status[BIT_COLL];
    status_set[BIT_IOTEST] = pattern_mismatch;
    status_set[BIT_PLL] = alarms_s.pll_unlocked;
    status_set[BIT_PA] = dual ? alarms_s.par_word[0] : alarms_s.par_rise;
    status_set[BIT_PB] = dual ? alarms_s.par_word[1] : alarms_s.par_fall;
    status_set[BIT_PC] = dual && alarms_s.par_word[2];
    status_set[BIT_PD] = dual && alarms_s.par_word[3];
    status_set = status_set & ~RESERVED_BITS;
  end

  always_comb begin
    do_write = (st_r.bus == BUS_WRITE) && st_r.size_ok;
    accept = hsel && hready && (htrans == HTRANS_NONSEQ) && (st_r.bus != BUS_RD_WAIT);
    status_clr = 16'h0000;
    if (do_write && (st_r.addr == STATUS_ADDR)) begin
      status_clr = hwdata[15:0];
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_pend = 1'b0;

    if (do_write) begin
      if (st_r.addr == MASK_ADDR) begin
        st_nxt.mask = hwdata[15:0];
      end else if (st_r.addr == CTRL_ADDR) begin
        st_nxt.ctrl = hwdata[2:0] & ~(3'h1 << CTRL_SYNC);
        st_nxt.sync_pend = hwdata[CTRL_SYNC];
      end
    end

    case (st_r.bus)
      BUS_RD_WAIT: begin
        if (st_r.addr == STATUS_ADDR) begin
          st_nxt.rdata = {16'h0000, status & ~RESERVED_BITS};
        end else if (st_r.addr == MASK_ADDR) begin
          st_nxt.rdata = {16'h0000, st_r.mask};
        end else if (st_r.addr == CTRL_ADDR) begin
          st_nxt.rdata = {29'h0, st_r.ctrl};
        end else begin
          st_nxt.rdata = 32'h0000_0000;
        end
        st_nxt.bus = BUS_RD_DONE;
      end
      default: begin
        if (accept) begin
          st_nxt.addr = haddr[11:0];
          st_nxt.size_ok = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
          st_nxt.bus = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          st_nxt.bus = BUS_IDLE;
        end
      end
    endcase

    // Zero pointer cannot rotate out of itself; held until a sync reloads it
    if (sync_event || st_r.sync_pend) begin
      st_nxt.wr_ptr = sync_ptr_value;
    end else if (fifo_wr_advance && !ptr_zero) begin
      st_nxt.wr_ptr = {st_r.wr_ptr[6:0], st_r.wr_ptr[7]};
    end

    for (int i = 0; i < 4; i++) begin
      st_nxt.samples.ch[i] = status[BIT_OUTGONE] ? MIDSCALE : samples_in.ch[i];
    end
    st_nxt.alarm = |(status & ~st_r.mask & ~RESERVED_BITS);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r.bus <= BUS_IDLE;
      st_r.addr <= 12'h000;
      st_r.size_ok <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.mask <= MASK_RESET;
      st_r.ctrl <= CTRL_RESET;
      st_r.sync_pend <= 1'b0;
      st_r.wr_ptr <= PTR_RESET;
      st_r.samples <= {4{MIDSCALE}};
      st_r.alarm <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = (st_r.bus != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign fifo_wr_ptr = st_r.wr_ptr;
  assign pattern_mode = st_r.ctrl[CTRL_PATTERN];
  assign samples_out = st_r.samples;
  assign alarm_out = st_r.alarm;
endmodule : alarm_status_regs

`default_nettype wire

// File: verif/alarm_props.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_props
  import alarm_pkg::*;
(
  // Clock and bus
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic [31:0] haddr,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  // FIFO, alarms, data
  input wire async_alarms_t async_alarms,
  input wire logic fifo_wr_advance,
  input wire logic sync_event,
  input wire logic [7:0] sync_ptr_value,
  input wire logic [7:0] fifo_wr_ptr,
  input wire logic [7:0] fifo_rd_ptr,
  input wire samples_t samples_in,
  input wire samples_t samples_out
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic req = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic mid = samples_out == {4{MIDSCALE}};
  // Soft sync from the bus reloads the pointer as a sync input does
  logic ctrl_wr_r;
  logic soft_sync_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_wr_r <= 1'b0;
      soft_sync_r <= 1'b0;
    end else begin
      ctrl_wr_r <= req && hwrite && haddr[11:0] == CTRL_ADDR && hsize == HSIZE_WORD;
      soft_sync_r <= ctrl_wr_r && hwdata[CTRL_SYNC];
    end
  end
  AST_RD_WAIT: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  AST_WR_ZERO_WAIT: assert property (req && hwrite |=> hreadyout)
    else $error("write wait wrong");
  AST_FREEZE: assert property (
    fifo_wr_ptr == 8'h00 && !sync_event && !soft_sync_r |=> fifo_wr_ptr == 8'h00)
    else $error("zero pointer moved");
  AST_ADVANCE: assert property (fifo_wr_ptr != 8'h00 && fifo_wr_advance && !sync_event
    && !soft_sync_r |=> fifo_wr_ptr == {$past(fifo_wr_ptr[6:0]), $past(fifo_wr_ptr[7])})
    else $error("pointer shift wrong");
  AST_SOFT_SYNC: assert property (soft_sync_r |=> fifo_wr_ptr == $past(sync_ptr_value))
    else $error("soft sync load wrong");
  AST_SYNC: assert property (sync_event |=> fifo_wr_ptr == $past(sync_ptr_value))
    else $error("sync load wrong");
  AST_CLK_MID: assert property (
    (async_alarms.dacclk_stopped || async_alarms.input_data_clock_stopped)[*6] |-> mid)
    else $error("no midscale on clock loss");
  AST_COLL_MID: assert property (
    (fifo_wr_ptr == fifo_rd_ptr && fifo_wr_ptr != 8'h00)[*4] |-> mid)
    else $error("no midscale on collision");
  AST_PASS: assert property (!mid |-> samples_out == $past(samples_in))
    else $error("data path wrong");
endmodule : alarm_props
bind alarm_status_regs alarm_props u_props (
  .mclk(mclk),
  .rst(rst),
  .hsel(hsel),
  .hready(hready),
  .htrans(htrans),
  .hwrite(hwrite),
  .hreadyout(hreadyout),
  .haddr(haddr),
  .hsize(hsize),
  .hwdata(hwdata),
  .async_alarms(async_alarms),
  .fifo_wr_advance(fifo_wr_advance),
  .sync_event(sync_event),
  .sync_ptr_value(sync_ptr_value),
  .fifo_wr_ptr(fifo_wr_ptr),
  .fifo_rd_ptr(fifo_rd_ptr),
  .samples_in(samples_in),
  .samples_out(samples_out)
);
`default_nettype wire

// File: verif/ahb_host.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_host
  import alarm_pkg::*;
(
  // Bus
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output var logic [31:0] haddr = 32'h0,
  output var logic [1:0] htrans = 2'h0,
  output var logic hwrite = 1'b0,
  output var logic [31:0] hwdata = 32'h0
);
  // Called right after a rising edge; waits on hready with no assumed latency
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hready);
    q = hrdata;
  endtask : xfer
endmodule : ahb_host
`default_nettype wire

// File: verif/dac_alarm_status_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module dac_alarm_status_register_test
  import alarm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic hwrite, hreadyout, hresp, fifo_wr_advance = 1'b0, sync_event = 1'b0;
  logic pattern_mismatch = 1'b0, pattern_mode, alarm_out;
  logic [7:0] fifo_rd_ptr = 8'h40, sync_ptr_value = 8'h00, fifo_wr_ptr;
  async_alarms_t async_alarms = '0;
  samples_t samples_in = '0, samples_out;
  wire logic hready = hreadyout;
  int n_errors = 0, check_count = 0, cyc = 0, seed = 63;
  alarm_status_regs uut (
    .mclk(mclk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .async_alarms(async_alarms),
    .pattern_mismatch(pattern_mismatch),
    .fifo_wr_advance(fifo_wr_advance),
    .fifo_rd_ptr(fifo_rd_ptr),
    .sync_event(sync_event),
    .sync_ptr_value(sync_ptr_value),
    .fifo_wr_ptr(fifo_wr_ptr),
    .pattern_mode(pattern_mode),
    .samples_in(samples_in),
    .samples_out(samples_out),
    .alarm_out(alarm_out)
  );
  ahb_host host (
    .mclk(mclk),
    .hready(hready),
    .hrdata(hrdata),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata)
  );
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    samples_in <= {$random(seed), $random(seed)};
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask : cy
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, rv);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rv);
  endtask : wr
  // Twice: output-gone re-arms while its cause bit is still set
  task automatic clr();
    wr(STATUS_ADDR, 32'hffff);
    wr(STATUS_ADDR, 32'hffff);
  endtask : clr
  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] ea(input int i, input logic dual);
    case (i)
      8: return 16'h0500;
      7: return 16'h0300;
      6: return 16'h0020;
      5: return dual ? 16'h0000 : 16'h0010;
      4: return dual ? 16'h0000 : 16'h0008;
      default: return dual ? 16'h0010 >> i : 16'h0000;
    endcase
  endfunction : ea
  initial begin
    cy(16);
    rst <= 1'b0;
    @(posedge mclk);
    rd(MASK_ADDR);
    chk("mask", rv, 32'hffff);
    chk("hresp", hresp, 1'b0);
    // Halfword write must be refused
    hsize <= 3'h1;
    wr(MASK_ADDR, 32'h0);
    hsize <= HSIZE_WORD;
    rd(MASK_ADDR);
    chk("mask_size", rv, 32'hffff);
    rd(12'h3fc);
    chk("unmapped", rv, 32'h0);
    for (int k = 0; k < 3; k++) begin
      fifo_rd_ptr <= 8'h04 >> k;
      cy(5);
      rd(STATUS_ADDR);
      chk("fifo", rv, k == 2 ? 32'h2100 : 32'h0800 << k);
      fifo_rd_ptr <= 8'h40;
      clr();
    end
    sync_event <= 1'b1;
    @(posedge mclk);
    sync_event <= 1'b0;
    fifo_wr_advance <= 1'b1;
    cy(4);
    fifo_wr_advance <= 1'b0;
    chk("ptr", fifo_wr_ptr, 8'h00);
    rd(STATUS_ADDR);
    chk("zero", rv, 32'h8000);
    sync_ptr_value <= 8'h01;
    sync_event <= 1'b1;
    @(posedge mclk);
    sync_event <= 1'b0;
    fifo_wr_advance <= 1'b1;
    @(posedge mclk);
    fifo_wr_advance <= 1'b0;
    clr();
    rd(STATUS_ADDR);
    chk("clean", rv, 32'h0);
    // Soft sync through the control register loads a zero pointer
    sync_ptr_value <= 8'h00;
    wr(CTRL_ADDR, 32'h4);
    cy(2);
    chk("soft_ptr", fifo_wr_ptr, 8'h00);
    rd(CTRL_ADDR);
    chk("ctrl", rv, 32'h0);
    rd(STATUS_ADDR);
    chk("soft_zero", rv, 32'h8000);
    sync_ptr_value <= 8'h01;
    sync_event <= 1'b1;
    @(posedge mclk);
    sync_event <= 1'b0;
    clr();
    for (int d = 0; d < 2; d++) begin
      wr(CTRL_ADDR, d | 2);
      for (int i = 0; i < 9; i++) begin
        async_alarms <= async_alarms_t'(9'h1 << i);
        cy(6);
        chk("pmode", pattern_mode, 1'b1);
        if (i > 6) chk("mid", samples_out, {4{MIDSCALE}});
        async_alarms <= '0;
        cy(4);
        rd(STATUS_ADDR);
        chk("alarm", rv, ea(i, d[0]));
        clr();
      end
    end
    pattern_mismatch <= 1'b1;
    @(posedge mclk);
    pattern_mismatch <= 1'b0;
    cy(3);
    rd(STATUS_ADDR);
    chk("pattern", rv, 32'h0080);
    wr(MASK_ADDR, 32'hff7f);
    cy(3);
    chk("alarm_out", alarm_out, 1'b1);
    // Mid-run reset brings alarm pin, pointer, midscale output, mask and status back
    rst <= 1'b1;
    cy(2);
    rst <= 1'b0;
    @(posedge mclk);
    chk("rst_alarm", alarm_out, 1'b0);
    chk("rst_ptr", fifo_wr_ptr, PTR_RESET);
    chk("rst_mid", samples_out, {4{MIDSCALE}});
    rd(MASK_ADDR);
    chk("rst_mask", rv, 32'hffff);
    rd(STATUS_ADDR);
    chk("rst_status", rv, 32'h0);
    wrap_up();
  end
endmodule : dac_alarm_status_register_test
`default_nettype wire
